// ==== core/pfm_defines.svh ====
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

// Register offsets on the plain register port
`define PFM_ADDR_W        4
`define PFM_OFS_PA_LOW    4'h0
`define PFM_OFS_PA_HIGH   4'h1
`define PFM_OFS_PB_LOW    4'h2
`define PFM_OFS_PB_HIGH   4'h3
`define PFM_OFS_PC_LOW    4'h4
`define PFM_OFS_PC_HIGH   4'h5
`define PFM_OFS_IN_SEL    4'h6

// Reset values and input selector write mask
`define PFM_SEL_RESET     8'h00
`define PFM_IN_SEL_RESET  8'h00
`define PFM_IN_SEL_MASK   8'h3F

// Input selector bit that routes the shared data input
`define PFM_IN_SEL_SDA    0

// Product variant codes
`define PFM_VAR_A         2'h0
`define PFM_VAR_B         2'h1
`define PFM_VAR_C         2'h2
`define PFM_VAR_D         2'h3

`endif

// ==== core/pfm_pkg.sv ====
package pfm_pkg;

  // Function a pin is given
  typedef enum logic [4:0] {
    PFM_GPIO,
    PFM_SERIAL_CS,
    PFM_CRYSTAL_ONE,
    PFM_CRYSTAL_TWO,
    PFM_CT0_OUT,
    PFM_CT0_OUT_INV,
    PFM_LCD_BIAS2,
    PFM_LCD_CAP_ONE,
    PFM_LCD_CAP_TWO,
    PFM_SERIAL_DOUT,
    PFM_SERIAL_DIN_SHARED,
    PFM_SERIAL_CLK,
    PFM_UART_RX,
    PFM_UART_TX,
    PFM_PT_OUT,
    PFM_PT_OUT_INV,
    PFM_VREF_IN,
    PFM_ANALOG,
    PFM_TOUCH_KEY,
    PFM_LCD_SEGMENT
  } pfm_func_type;

  // Decoded routing of one pin
  typedef struct packed {
    pfm_func_type func;
    logic [4:0]   index;
  } pfm_route_type;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pfm_bus_type;

endpackage

// ==== core/pfm_pin_mux.sv ====
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "pfm_defines.svh"
// How it works
// - PA3 field: 00/11 general I/O, 01 serial chip select, 10 crystal pin one.
// - PA1 field: 00/10 general I/O, 01 capture timer zero out, 11 LCD bias two.
// - PA0 field: 01 serial data out, every other code general I/O.
// - PA7 field: 00/01 I/O, 10 touch key, 11 LCD segment, index per variant.
// - PA6 field: 00/01/10 I/O with timer clock and irq zero, 11 pump cap two.
// - PA5 field: 00/10 I/O, 01 inverted capture timer out, 11 pump cap one.
// - PA4 field: 00/11 I/O, 01 serial data out, 10 crystal pin two.
// - PB3 field: 00/10 I/O with irq zero, 01 UART receive, 11 analog three.
// - PB2 field: 00 I/O with capture in, 01 UART transmit, 10 timer out, 11 analog two.
// - PB1 field: 00/10 I/O, 01 shared serial clock, 11 analog one.
// - PB7 field: 00/01 I/O with irq one, 10 key four, 11 analog seven.
// - PB6 field: 00/01 I/O with timer clock, 10 key three, 11 analog six.
// - PB5 field: 00/01 I/O with standard clock, 10 key two, 11 analog five.
// - PB4 field: 00 I/O, 01 inverted timer out, 10 key one, 11 analog four.
// - PC3 field: 10 key eight, 11 segment three unless variant keeps I/O.
// - PC2 field: 10 key seven, 11 segment two unless variant keeps I/O.
// - PC1 field: 10 key six, 11 segment one unless variant keeps I/O.
// - PC0 field: 10 key five, 11 segment zero unless variant keeps I/O.
// - Shared data input reaches its peripheral only when the input selector routes it.
module pfm_pin_mux (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  // Product variant strap
  input  wire logic [1:0]              variant,
  // Register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // Shared serial data pin input
  input  wire logic                    serial_data_pin_in,
  output logic                         serial_data_in_shared,
  // Decoded routing, pins 0..7 of port A, port B, then port C 0..3
  output pfm_pkg::pfm_route_type [7:0] port_a_route,
  output pfm_pkg::pfm_route_type [7:0] port_b_route,
  output pfm_pkg::pfm_route_type [3:0] port_c_route
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]   port_a_low_pin_select_reg;
  logic [7:0]   port_a_high_pin_select_reg;
  logic [7:0]   port_b_low_pin_select_reg;
  logic [7:0]   port_b_high_pin_select_reg;
  logic [7:0]   port_c_low_pin_select_reg;
  logic [7:0]   port_c_high_pin_select_reg;
  logic [7:0]   input_function_selector_reg;
  logic [1:0]   variant_reg;
  logic         strap_done_reg;

  // Selection writes; reset puts every field at code 00
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      port_a_low_pin_select_reg   <= `PFM_SEL_RESET;
      port_a_high_pin_select_reg  <= `PFM_SEL_RESET;
      port_b_low_pin_select_reg   <= `PFM_SEL_RESET;
      port_b_high_pin_select_reg  <= `PFM_SEL_RESET;
      port_c_low_pin_select_reg   <= `PFM_SEL_RESET;
      port_c_high_pin_select_reg  <= `PFM_SEL_RESET;
      input_function_selector_reg <= `PFM_IN_SEL_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `PFM_OFS_PA_LOW:  port_a_low_pin_select_reg   <= reg_wdata;
        `PFM_OFS_PA_HIGH: port_a_high_pin_select_reg  <= reg_wdata;
        `PFM_OFS_PB_LOW:  port_b_low_pin_select_reg   <= reg_wdata;
        `PFM_OFS_PB_HIGH: port_b_high_pin_select_reg  <= reg_wdata;
        `PFM_OFS_PC_LOW:  port_c_low_pin_select_reg   <= reg_wdata;
        `PFM_OFS_PC_HIGH: port_c_high_pin_select_reg  <= reg_wdata;
        `PFM_OFS_IN_SEL:  input_function_selector_reg <= reg_wdata & `PFM_IN_SEL_MASK;
        default: ;
      endcase
    end
  end

  // Variant strap caught once after reset release, never from the port at reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      variant_reg    <= `PFM_VAR_A;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      variant_reg    <= variant;
      strap_done_reg <= 1'b1;
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PFM_OFS_PA_LOW:  reg_rdata <= port_a_low_pin_select_reg;
        `PFM_OFS_PA_HIGH: reg_rdata <= port_a_high_pin_select_reg;
        `PFM_OFS_PB_LOW:  reg_rdata <= port_b_low_pin_select_reg;
        `PFM_OFS_PB_HIGH: reg_rdata <= port_b_high_pin_select_reg;
        `PFM_OFS_PC_LOW:  reg_rdata <= port_c_low_pin_select_reg;
        `PFM_OFS_PC_HIGH: reg_rdata <= port_c_high_pin_select_reg;
        `PFM_OFS_IN_SEL:  reg_rdata <= input_function_selector_reg;
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic pfm_pkg::pfm_route_type mk(input pfm_pkg::pfm_func_type f, input logic [4:0] i);
    pfm_pkg::pfm_route_type r;
    r.func  = f;
    r.index = i;
    return r;
  endfunction

  localparam pfm_pkg::pfm_route_type GPIO = '{func: pfm_pkg::PFM_GPIO, index: 5'h00};

  pfm_pkg::pfm_route_type [7:0] pa_next;
  pfm_pkg::pfm_route_type [7:0] pb_next;
  pfm_pkg::pfm_route_type [3:0] pc_next;

  // Port A decode; PA2 field has no alternate function here
  // Each decode keeps its own field scratch so no variable has two drivers
  always_comb begin
    logic [1:0] f;
    f       = 2'h0;
    pa_next = {8{GPIO}};
    f = port_a_low_pin_select_reg[1:0];
    if (f == 2'h1) pa_next[0] = mk(pfm_pkg::PFM_SERIAL_DOUT, 5'h00);
    f = port_a_low_pin_select_reg[3:2];
    if (f == 2'h1) pa_next[1] = mk(pfm_pkg::PFM_CT0_OUT, 5'h00);
    if (f == 2'h3) pa_next[1] = mk(pfm_pkg::PFM_LCD_BIAS2, 5'h00);
    f = port_a_low_pin_select_reg[7:6];
    if (f == 2'h1) pa_next[3] = mk(pfm_pkg::PFM_SERIAL_CS, 5'h00);
    if (f == 2'h2) pa_next[3] = mk(pfm_pkg::PFM_CRYSTAL_ONE, 5'h00);
    f = port_a_high_pin_select_reg[1:0];
    if (f == 2'h1) pa_next[4] = mk(pfm_pkg::PFM_SERIAL_DOUT, 5'h00);
    if (f == 2'h2) pa_next[4] = mk(pfm_pkg::PFM_CRYSTAL_TWO, 5'h00);
    f = port_a_high_pin_select_reg[3:2];
    if (f == 2'h1) pa_next[5] = mk(pfm_pkg::PFM_CT0_OUT_INV, 5'h00);
    if (f == 2'h3) pa_next[5] = mk(pfm_pkg::PFM_LCD_CAP_ONE, 5'h00);
    // Codes 00..10 leave timer clock and irq zero inputs on the I/O pin
    f = port_a_high_pin_select_reg[5:4];
    if (f == 2'h3) pa_next[6] = mk(pfm_pkg::PFM_LCD_CAP_TWO, 5'h00);
    // Touch key and segment index differ between variants
    f = port_a_high_pin_select_reg[7:6];
    if (f == 2'h2) pa_next[7] = mk(pfm_pkg::PFM_TOUCH_KEY, (variant_reg == `PFM_VAR_A) ? 5'd12 : 5'd20);
    if (f == 2'h3) pa_next[7] = mk(pfm_pkg::PFM_LCD_SEGMENT, variant_reg[1] ? 5'd15 : 5'd7);
  end

  // Port B decode
  always_comb begin
    logic [1:0] f;
    f       = 2'h0;
    pb_next = {8{GPIO}};
    f = port_b_low_pin_select_reg[1:0];
    if (f == 2'h1) pb_next[0] = mk(pfm_pkg::PFM_SERIAL_DIN_SHARED, 5'h00);
    if (f == 2'h2) pb_next[0] = mk(pfm_pkg::PFM_VREF_IN, 5'h00);
    if (f == 2'h3) pb_next[0] = mk(pfm_pkg::PFM_ANALOG, 5'd0);
    f = port_b_low_pin_select_reg[3:2];
    if (f == 2'h1) pb_next[1] = mk(pfm_pkg::PFM_SERIAL_CLK, 5'h00);
    if (f == 2'h3) pb_next[1] = mk(pfm_pkg::PFM_ANALOG, 5'd1);
    f = port_b_low_pin_select_reg[5:4];
    if (f == 2'h1) pb_next[2] = mk(pfm_pkg::PFM_UART_TX, 5'h00);
    if (f == 2'h2) pb_next[2] = mk(pfm_pkg::PFM_PT_OUT, 5'h00);
    if (f == 2'h3) pb_next[2] = mk(pfm_pkg::PFM_ANALOG, 5'd2);
    f = port_b_low_pin_select_reg[7:6];
    if (f == 2'h1) pb_next[3] = mk(pfm_pkg::PFM_UART_RX, 5'h00);
    if (f == 2'h3) pb_next[3] = mk(pfm_pkg::PFM_ANALOG, 5'd3);
    f = port_b_high_pin_select_reg[1:0];
    if (f == 2'h1) pb_next[4] = mk(pfm_pkg::PFM_PT_OUT_INV, 5'h00);
    if (f == 2'h2) pb_next[4] = mk(pfm_pkg::PFM_TOUCH_KEY, 5'd1);
    if (f == 2'h3) pb_next[4] = mk(pfm_pkg::PFM_ANALOG, 5'd4);
    f = port_b_high_pin_select_reg[3:2];
    if (f == 2'h2) pb_next[5] = mk(pfm_pkg::PFM_TOUCH_KEY, 5'd2);
    if (f == 2'h3) pb_next[5] = mk(pfm_pkg::PFM_ANALOG, 5'd5);
    f = port_b_high_pin_select_reg[5:4];
    if (f == 2'h2) pb_next[6] = mk(pfm_pkg::PFM_TOUCH_KEY, 5'd3);
    if (f == 2'h3) pb_next[6] = mk(pfm_pkg::PFM_ANALOG, 5'd6);
    f = port_b_high_pin_select_reg[7:6];
    if (f == 2'h2) pb_next[7] = mk(pfm_pkg::PFM_TOUCH_KEY, 5'd4);
    if (f == 2'h3) pb_next[7] = mk(pfm_pkg::PFM_ANALOG, 5'd7);
  end

  // Port C low decode; variant B has no LCD segments on these pins
  always_comb begin
    logic [1:0] f;
    f       = 2'h0;
    pc_next = {4{GPIO}};
    for (int i = 0; i < 4; i++) begin
      f = port_c_low_pin_select_reg[2*i +: 2];
      if (f == 2'h2) pc_next[i] = mk(pfm_pkg::PFM_TOUCH_KEY, 5'(i + 5));
      if (f == 2'h3 && variant_reg != `PFM_VAR_B) begin
        pc_next[i] = mk(pfm_pkg::PFM_LCD_SEGMENT, 5'(i));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Routing follows the register one cycle later
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      port_a_route <= {8{GPIO}};
      port_b_route <= {8{GPIO}};
      port_c_route <= {4{GPIO}};
    end else begin
      port_a_route <= pa_next;
      port_b_route <= pb_next;
      port_c_route <= pc_next;
    end
  end

  // Shared data input gated by the input selector alone; the output field plays no part
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      serial_data_in_shared <= 1'b0;
    end else begin
      serial_data_in_shared <= input_function_selector_reg[`PFM_IN_SEL_SDA] & serial_data_pin_in;
    end
  end

endmodule

// ==== tb/pfm_pin_mux_properties.sv ====
`timescale 1ns/1ps
////////////////////////////////////////
// Port-level checks on the pin function multiplexer
module pfm_pin_mux_properties (
  // Clock and reset
  input wire logic                         mclk,
  input wire logic                         rstn,
  // Register port
  input wire logic [3:0]                   reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_rdata,
  // Shared input and routes
  input wire logic                         serial_data_pin_in,
  input wire logic                         serial_data_in_shared,
  input wire pfm_pkg::pfm_route_type [7:0] port_a_route,
  input wire pfm_pkg::pfm_route_type [7:0] port_b_route,
  input wire pfm_pkg::pfm_route_type [3:0] port_c_route
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Field write reaches its pin two edges on; a later write cannot mask it
  property p_dec(hit, got, exp);
    hit |-> ##2 got == exp;
  endproperty

  ////////////////////////////////////////
  chk_pa0_sdo: assert property (p_dec(reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] == 2'h1,
    port_a_route[0].func, pfm_pkg::PFM_SERIAL_DOUT)) else $error("pin A0 not on serial out");
  chk_pa3_cs: assert property (p_dec(reg_wr && reg_addr == 4'h0 && reg_wdata[7:6] == 2'h1,
    port_a_route[3].func, pfm_pkg::PFM_SERIAL_CS)) else $error("pin A3 not on chip select");
  chk_pb0_shared: assert property (p_dec(reg_wr && reg_addr == 4'h2 && reg_wdata[1:0] == 2'h1,
    port_b_route[0].func, pfm_pkg::PFM_SERIAL_DIN_SHARED)) else $error("pin B0 not on shared data");
  chk_pb7_key: assert property (p_dec(reg_wr && reg_addr == 4'h3 && reg_wdata[7:6] == 2'h2,
    port_b_route[7], {pfm_pkg::PFM_TOUCH_KEY, 5'h04})) else $error("pin B7 not on key four");
  chk_pc0_key: assert property (p_dec(reg_wr && reg_addr == 4'h4 && reg_wdata[1:0] == 2'h2,
    port_c_route[0], {pfm_pkg::PFM_TOUCH_KEY, 5'h05})) else $error("pin C0 not on key five");
  chk_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside read cycle");
  chk_sdi_gate: assert property (serial_data_in_shared |-> $past(serial_data_pin_in))
    else $error("shared input high without pin");
  chk_route_hold: assert property ($changed(port_c_route) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 4'h4)
    else $error("port C route moved without write");

  // Main scenarios reached
  cov_write: cover property (reg_wr);
  cov_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
  cov_sdi: cover property (serial_data_in_shared);
endmodule

// ==== tb/test_pfm_pin_mux.sv ====
`timescale 1ns/1ps
////////////////////////////////////////
module test_pfm_pin_mux;
  // Design ports
  logic                         mclk;
  logic                         rstn;
  logic [1:0]                   variant;
  logic [3:0]                   reg_addr;
  logic [7:0]                   reg_wdata;
  logic                         reg_wr;
  logic                         reg_rd;
  logic [7:0]                   reg_rdata;
  logic                         serial_data_pin_in;
  logic                         serial_data_in_shared;
  pfm_pkg::pfm_route_type [7:0] port_a_route;
  pfm_pkg::pfm_route_type [7:0] port_b_route;
  pfm_pkg::pfm_route_type [3:0] port_c_route;
  // Bench state
  int                           err_total;
  int                           comparisons;
  int                           cycles;
  pfm_pkg::pfm_route_type       rt;
  // Port, pin, then function code for fields 00, 01, 10, 11 on variant 0
  logic [39:0]                  rows [19] = '{40'h00_00090000, 40'h01_00040006, 40'h03_00010200, 40'h04_00090300,
    40'h05_00050007, 40'h06_00000008, 40'h07_00001213, 40'h10_000A1011, 40'h11_000B0011, 40'h12_000D0E11,
    40'h13_000C0011, 40'h14_000F1211, 40'h15_00001211, 40'h16_00001211, 40'h17_00001211, 40'h20_00001213,
    40'h21_00001213, 40'h22_00001213, 40'h23_00001213};

  pfm_pin_mux dut_u (.mclk(mclk), .rstn(rstn), .variant(variant), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_data_pin_in(serial_data_pin_in),
    .serial_data_in_shared(serial_data_in_shared), .port_a_route(port_a_route), .port_b_route(port_b_route),
    .port_c_route(port_c_route));

  // 125 MHz clock and hang guard
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One-cycle strobes, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // Routes lag the register by one edge
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // Strap is taken at the first edge after release, so it is set with reset low
  task automatic do_reset(input logic [1:0] v);
    @(posedge mclk);
    rstn    <= 1'b0;
    variant <= v;
    repeat (4) @(posedge mclk);
    rstn    <= 1'b1;
  endtask

  task automatic check_pin(input int r, input int c);
    logic [39:0] row;
    logic [7:0]  f;
    logic [7:0]  idx;
    row = rows[r];
    f = row[31-8*c-:8];
    idx = {4'h0, row[35:32]};
    case (row[39:36])
      4'h0: rt = port_a_route[row[34:32]];
      4'h1: rt = port_b_route[row[34:32]];
      default: rt = port_c_route[row[33:32]];
    endcase
    if (f == 8'h12) idx = (row[39:36] == 4'h1) ? idx - 8'h03 : (row[39:36] == 4'h2) ? idx + 8'h05 : 8'h0C;
    if (f == 8'h13 && row[39:36] == 4'h0) idx = 8'h07;
    check({3'h0, rt.func}, f);
    if (f >= 8'h11) check({3'h0, rt.index}, idx);
  endtask

  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    variant = 2'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    serial_data_pin_in = 1'b0;
    do_reset(2'h0);
    settle();
    foreach (rows[r]) check_pin(r, 0);
    for (int a = 0; a < 7; a++) rd(4'(a), 8'h00);
    // Every code on every decoded field, then read back
    for (int c = 0; c < 4; c++) begin
      for (int a = 0; a < 5; a++) wr(4'(a), {4{2'(c)}});
      settle();
      foreach (rows[r]) check_pin(r, c);
      for (int a = 0; a < 5; a++) rd(4'(a), {4{2'(c)}});
    end
    // Stored-only, unmapped and input selector places
    wr(4'h5, 8'hA5);
    rd(4'h5, 8'hA5);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(4'h6, 8'hFF);
    rd(4'h6, 8'h3F);
    @(posedge mclk);
    serial_data_pin_in <= 1'b1;
    settle();
    check({7'h00, serial_data_in_shared}, 8'h01);
    wr(4'h6, 8'h3E);
    settle();
    check({7'h00, serial_data_in_shared}, 8'h00);
    // Variant that keeps port C as I/O on code 11
    do_reset(2'h1);
    wr(4'h4, 8'hFF);
    wr(4'h1, 8'hC0);
    settle();
    check({3'h0, port_c_route[0].func}, 8'h00);
    check({3'h0, port_a_route[7].index}, 8'h07);
    wr(4'h1, 8'h80);
    settle();
    check({3'h0, port_a_route[7].index}, 8'h14);
    // Larger variant moves the segment index
    do_reset(2'h2);
    wr(4'h4, 8'hFF);
    wr(4'h1, 8'hC0);
    settle();
    check({3'h0, port_c_route[3].func}, 8'h13);
    check({3'h0, port_c_route[3].index}, 8'h03);
    check({3'h0, port_a_route[7].index}, 8'h0F);
    wrap_up();
  end
endmodule

bind pfm_pin_mux pfm_pin_mux_properties chk_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_data_pin_in(serial_data_pin_in), .serial_data_in_shared(serial_data_in_shared),
  .port_a_route(port_a_route), .port_b_route(port_b_route), .port_c_route(port_c_route));
